// file: inc/dmsep_defs.svh
/*
  Constants of the dual-mode serial EEPROM port: bus address, stream
  framing, mode-transition counts and the write-cycle time.
  Assumes a 10 MHz system clock.
*/
// ============================================================
// Overview of operation
// - Power-up starts streaming with the address pointer at zero.
// - Stream bytes go MSB first, eight bits, then one null bit slot.
// - Each stream bit is presented on a rising stream clock edge.
// - Stream addresses run consecutively and wrap from 7Fh to 00h.
// - Nine stream clocks after power-up, SDA released during them.
// - Tenth stream clock rising edge presents MSB of location 00h.
// - SCL falling edge while streaming enters the transition state.
// - Every SCL falling edge in transition clears the pulse counter.
// - 128 pulses with SCL idle return to streaming from 00h MSB.
// - Recognised control byte locks slave mode until power loss.
// - In slave mode the stream clock only enables writes, held high.
// - A started programming cycle ignores the stream clock input.
// - Slave answers only address 1010000 plus direction bit.
// - SDA falling while SCL high is a Start condition.
// - SDA rising while SCL high is a Stop condition.
// - SDA changes only while SCL low; high-phase changes are Start/Stop.
// - Excess write bytes keep the last eight, overwriting oldest first.
// - Receiver pulls SDA low through the ninth clock's high phase.
// - No acknowledge at all while programming is in progress.
// - Master not-acknowledge ends a read; device releases SDA.
// - Byte write: control, word address, data, each acked; Stop programs.
`ifndef DMSEP_DEFS_SVH
`define DMSEP_DEFS_SVH

`define DMSEP_DEV_ADDR     7'h50
`define DMSEP_INIT_PULSES  4'h9
`define DMSEP_NULL_SLOT    4'h8
`define DMSEP_BYTE_BITS    4'h8
`define DMSEP_REVERT_LAST  8'h7F
`define DMSEP_CLK_HZ       10000000
`define DMSEP_TWR_MS       10
`define DMSEP_TWR_CYC      (`DMSEP_TWR_MS * (`DMSEP_CLK_HZ / 1000))

`endif

// file: inc/dmsep_pkg.sv
/*
  Types of the dual-mode serial EEPROM port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dmsep_pkg;

  typedef enum logic [1:0] {
    DMSEP_STREAM,
    DMSEP_TRANS,
    DMSEP_BIDIR
  } dmsep_mode_e;

  typedef enum logic [2:0] {
    I_IDLE,
    I_DEV,
    I_WADDR,
    I_WDATA,
    I_ACK,
    I_RDATA,
    I_RACK
  } dmsep_i2c_e;

  typedef struct packed {
    dmsep_mode_e mode;
    logic        busy;
    logic        wr_enable;
  } dmsep_stat_s;

endpackage

// file: verification/dmsep_host.sv
/*
  Host model: drives SCL, the stream clock and its side of SDA.
  Assumes SDA has a pull-up and is low when either party pulls it.
*/
module dmsep_host (
  input  wire logic clk_i,
  input  wire logic sda_oe_i,
  input  wire logic sda_d_i,
  output logic      scl_o,
  output wire logic sda_o,
  output logic      stream_clock_in_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H = 8;
  logic m_low;
  logic fast;

  // ============================================================
  // Wire and reset-time stream clock
  // ============================================================
  assign sda_o = ~(m_low | (sda_oe_i & ~sda_d_i));

  // The stream clock runs free only while reset is held, so the link
  // side sees its reset; afterwards it moves one pulse at a time.
  initial
  begin
    scl_o = 1'b1;
    m_low = 1'b0;
    stream_clock_in_o = 1'b0;
    fast = 1'b1;
    #7;
    while (fast)
    begin
      stream_clock_in_o = ~stream_clock_in_o;
      #40;
    end
    stream_clock_in_o = 1'b0;
  end

  // ============================================================
  // Pin sequences, all launched at the falling system clock edge
  // ============================================================
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic vpulse();
    stream_clock_in_o = 1'b1;
    hold(H);
    stream_clock_in_o = 1'b0;
    hold(H);
  endtask

  task automatic scl_blip();
    scl_o = 1'b0;
    hold(H);
    scl_o = 1'b1;
    hold(H);
  endtask

  task automatic start();
    m_low = 1'b0;
    hold(4);
    scl_o = 1'b1;
    hold(H);
    m_low = 1'b1;
    hold(H);
    scl_o = 1'b0;
    hold(4);
  endtask

  task automatic stop();
    m_low = 1'b1;
    hold(4);
    scl_o = 1'b1;
    hold(H);
    m_low = 1'b0;
    hold(H);
  endtask

  // Data moves only with SCL low; the line is read at the end of the
  // high phase, when both parties have settled.
  task automatic put_bit(input logic b, output logic seen);
    m_low = ~b;
    hold(4);
    scl_o = 1'b1;
    hold(H);
    seen = sda_o;
    scl_o = 1'b0;
    hold(4);
  endtask

  // A high ack_in leaves SDA released, a not-acknowledge on reads.
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      put_bit(tx[i], rx[i]);
    put_bit(ack_in, ack);
  endtask
endmodule

// file: verification/dmsep_port_test.sv
/*
  Self-checking bench of the dual-mode serial EEPROM port: stream
  start-up and wrap, transition and return, slave writes and reads.
  Assumes the host model dmsep_host and memory cleared by reset.
*/
module dmsep_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dmsep_pkg::*;
  localparam int WR = 400;
  typedef struct {
    string      nm;
    int         sel;
    logic [7:0] exp;
  } dmsep_note_s;
  logic        clk;
  logic        srst;
  logic        scl;
  logic        sda;
  logic        stream_clock_in;
  logic        sda_oe;
  logic        sda_d;
  dmsep_stat_s stat;
  logic [7:0]  rx;
  logic        ack;
  logic [7:0]  d;
  logic [7:0]  seen;
  logic [7:0]  q [$];
  logic [7:0]  mem_m [128];
  dmsep_note_s notes [$];
  int          miscompares;
  int          num_checks;
  event        take;

  dmsep_port #(.WR_CYCLES(WR)) dut (
    .clk_i             (clk),
    .srst_i            (srst),
    .stream_clock_in_i (stream_clock_in),
    .scl_i             (scl),
    .sda_i             (sda),
    .sda_o             (sda_d),
    .sda_oe_o          (sda_oe),
    .stat_o            (stat)
  );

  dmsep_host host (
    .clk_i    (clk),
    .sda_oe_i (sda_oe),
    .sda_d_i  (sda_d),
    .scl_o    (scl),
    .sda_o    (sda),
    .stream_clock_in_o   (stream_clock_in)
  );

  always #50 clk = ~clk;

  // ============================================================
  // Checking
  // ============================================================
  task automatic check(input string nm, input logic [7:0] s,
                       input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic note(input string nm, input int sel,
                      input logic [7:0] e);
    notes.push_back('{nm, sel, e});
    -> take;
  endtask

  always @(take)
    while (notes.size() > 0)
    begin
      case (notes[0].sel)
        0: seen = {7'h00, sda_oe};
        1: seen = {6'h00, stat.mode};
        2: seen = {7'h00, stat.busy};
        3: seen = rx;
        5: seen = {7'h00, stat.wr_enable};
        default: seen = {7'h00, ack};
      endcase
      check(notes[0].nm, seen, notes[0].exp);
      void'(notes.pop_front());
    end

  // ============================================================
  // Bus sequences
  // ============================================================
  task automatic wait_idle();
    int n;
    n = 0;
    while (stat.busy !== 1'b0 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 2000)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask

  task automatic send(input logic [7:0] b, input logic [7:0] ea);
    host.xfer(b, 1'b1, rx, ack);
    note("ack", 4, ea);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v [$]);
    host.start();
    send(8'hA0, 8'h00);
    send(a, 8'h00);
    foreach (v[i])
      send(v[i], 8'h00);
    host.stop();
  endtask

  task automatic rd(input logic [7:0] a, input int n);
    host.start();
    send(8'hA0, 8'h00);
    send(a, 8'h00);
    host.start();
    send(8'hA1, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      host.xfer(8'hFF, i == n - 1, rx, ack);
      note("data", 3, mem_m[(a + i) % 128]);
    end
    host.hold(4);
    note("release", 0, 8'h00);
    host.stop();
  endtask

  // ============================================================
  // Main sequence
  // ============================================================
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    miscompares = 0;
    num_checks = 0;
    void'($urandom(32'had97));
    d = 8'($urandom());
    foreach (mem_m[i])
      mem_m[i] = 8'h00;
    repeat (4) @(negedge clk);
    host.fast = 1'b0;
    @(negedge clk);
    srst = 1'b0;
    repeat (5) @(negedge clk);
    note("mode", 1, 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      host.vpulse();
      note("init", 0, 8'h00);
    end
    // Zero data bits pull SDA low; every ninth slot must let it go.
    for (int i = 0; i < 130 * 9; i++)
    begin
      host.vpulse();
      note("stream", 0, {7'h00, i % 9 != 8});
    end
    host.scl_blip();
    note("mode", 1, 8'h01);
    note("oe", 0, 8'h00);
    repeat (100) host.vpulse();
    host.scl_blip();
    repeat (127) host.vpulse();
    note("mode", 1, 8'h01);
    host.vpulse();
    note("mode", 1, 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      host.vpulse();
      note("restart", 0, {7'h00, i != 8});
    end
    host.scl_blip();
    host.stream_clock_in_o = 1'b1;
    wr(8'h7E, {d});
    mem_m[8'h7E] = d;
    note("mode", 1, 8'h02);
    note("busy", 2, 8'h01);
    note("wen", 5, 8'h01);
    host.stream_clock_in_o = 1'b0;
    host.start();
    send(8'hA0, 8'h01);
    host.stop();
    wait_idle();
    wr(8'h10, {8'h5A});
    note("wen", 5, 8'h00);
    note("busy", 2, 8'h00);
    wait_idle();
    host.stream_clock_in_o = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      q.push_back(8'h30 + 8'(i));
      mem_m[8'h20 + i % 8] = 8'h30 + 8'(i);
    end
    wr(8'h20, q);
    wait_idle();
    rd(8'h7E, 2);
    rd(8'h10, 1);
    rd(8'h20, 8);
    host.start();
    send(8'hA2, 8'h01);
    host.stop();
    repeat (128) host.vpulse();
    note("mode", 1, 8'h02);
    @(negedge clk);
    report_and_stop();
  end
endmodule

// file: verilog/dmsep_port.sv
/*
  Dual-mode serial EEPROM port: streaming on the stream clock, a
  transition state, and a two-wire slave with byte and page write.
  Assumes open-drain SDA resolved outside, srst_i held at power-up,
  and the stream clock running while srst_i is held.
*/
`include "dmsep_defs.svh"

module dmsep_port #(
  parameter int DEPTH     = 128,
  parameter int PAGE      = 8,
  parameter int WR_CYCLES = `DMSEP_TWR_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic                stream_clock_in_i,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe_o,
  output dmsep_pkg::dmsep_stat_s   stat_o
);
  import dmsep_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int PW = $clog2(PAGE);
  localparam int CW = $clog2(WR_CYCLES + 1);

  // ==========================================================
  // Link clock domain
  // Only a toggle per rising edge lives here, so memory stays on clk_i.
  // The toggle clears straight from srst_i: a synchronised link reset
  // would swallow the first stream pulses that follow power-up.
  logic tog;

  always_ff @(posedge stream_clock_in_i or posedge srst_i)
  begin
    if (srst_i)
      tog <= 1'b0;
    else
      tog <= ~tog;
  end

  // ==========================================================
  // System clock state
  typedef struct packed {
    logic                    scl_m;
    logic                    scl_s;
    logic                    scl_p;
    logic                    scl_f;
    logic                    sda_m;
    logic                    sda_s;
    logic                    sda_p;
    logic                    sda_f;
    logic                    vcl_m;
    logic                    vcl_s;
    logic                    vcl_p;
    logic                    vcl_f;
    logic                    tg_m;
    logic                    tg_s;
    logic                    tg_p;
    dmsep_mode_e             mode;
    logic [3:0]              init;
    logic [3:0]              bit_idx;
    logic [AW-1:0]           saddr;
    logic [7:0]              pcnt;
    dmsep_i2c_e              ist;
    dmsep_i2c_e              ist_nx;
    logic [3:0]              bcnt;
    logic [7:0]              sh;
    logic                    mack;
    logic [AW-1:0]           ptr;
    logic [PAGE-1:0][7:0]    pbuf;
    logic [PAGE-1:0]         pval;
    logic                    wen;
    logic                    busy;
    logic [CW-1:0]           bcy;
    logic                    oe;
    logic [DEPTH-1:0][7:0]   mem;
  } dmsep_st_s;

  dmsep_st_s st;
  dmsep_st_s next_st;

  // Two agreeing synchronised samples are needed before the filtered
  // level moves, which rejects spikes shorter than one clock.
  function automatic logic filt(input logic s,
                                input logic p,
                                input logic f);
    return (s == p) ? s : f;
  endfunction

  logic scl_nf;
  logic sda_nf;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic vrise;
  logic exp_bit;

  always_comb
  begin
    scl_nf   = filt(st.scl_s, st.scl_p, st.scl_f);
    sda_nf   = filt(st.sda_s, st.sda_p, st.sda_f);
    scl_rise = ~st.scl_f & scl_nf;
    scl_fall = st.scl_f & ~scl_nf;
    start_c  = st.scl_f & scl_nf & st.sda_f & ~sda_nf;
    stop_c   = st.scl_f & scl_nf & ~st.sda_f & sda_nf;
    vrise    = st.tg_s ^ st.tg_p;
    exp_bit  = st.mem[st.saddr][3'(4'h7 - st.bit_idx)];
  end

  always_comb
  begin
    next_st       = st;
    next_st.scl_m = scl_i;
    next_st.scl_s = st.scl_m;
    next_st.scl_p = st.scl_s;
    next_st.scl_f = scl_nf;
    next_st.sda_m = sda_i;
    next_st.sda_s = st.sda_m;
    next_st.sda_p = st.sda_s;
    next_st.sda_f = sda_nf;
    next_st.vcl_m = stream_clock_in_i;
    next_st.vcl_s = st.vcl_m;
    next_st.vcl_p = st.vcl_s;
    next_st.vcl_f = filt(st.vcl_s, st.vcl_p, st.vcl_f);
    next_st.tg_m  = tog;
    next_st.tg_s  = st.tg_m;
    next_st.tg_p  = st.tg_s;

    // The programming timer is untouched by the stream clock.
    if (st.busy)
    begin
      next_st.bcy = st.bcy - 1'b1;
      if (st.bcy == CW'(1))
        next_st.busy = 1'b0;
    end

    if (st.mode == DMSEP_STREAM)
    begin
      if (scl_fall)
      begin
        next_st.mode = DMSEP_TRANS;
        next_st.pcnt = 8'h00;
        next_st.oe   = 1'b0;
        next_st.ist  = I_IDLE;
      end
      else if (vrise)
      begin
        if (st.init != `DMSEP_INIT_PULSES)
        begin
          next_st.init = st.init + 4'h1;
          next_st.oe   = 1'b0;
        end
        else
        begin
          // Open drain: a one is sent by releasing the line.
          next_st.oe = (st.bit_idx == `DMSEP_NULL_SLOT) ?
                       1'b0 : ~exp_bit;
          if (st.bit_idx == `DMSEP_NULL_SLOT)
          begin
            next_st.bit_idx = 4'h0;
            next_st.saddr   = st.saddr + 1'b1;
          end
          else
            next_st.bit_idx = st.bit_idx + 4'h1;
        end
      end
    end
    else
    begin
      if (st.mode == DMSEP_TRANS)
      begin
        if (scl_fall)
          next_st.pcnt = 8'h00;
        else if (vrise)
        begin
          if (st.pcnt == `DMSEP_REVERT_LAST && st.scl_f)
          begin
            next_st.mode    = DMSEP_STREAM;
            next_st.saddr   = '0;
            next_st.bit_idx = 4'h0;
            next_st.oe      = 1'b0;
            next_st.ist     = I_IDLE;
          end
          else
            next_st.pcnt = st.pcnt + 8'h01;
        end
      end
      else if (!st.vcl_f && st.ist != I_IDLE &&
               st.ist != I_RDATA && st.ist != I_RACK)
        next_st.wen = 1'b0;
      if (start_c)
      begin
        next_st.ist  = I_DEV;
        next_st.bcnt = 4'h0;
        next_st.oe   = 1'b0;
        next_st.wen  = st.vcl_f;
        next_st.pval = '0;
      end
      else if (stop_c)
      begin
        next_st.ist = I_IDLE;
        next_st.oe  = 1'b0;
        next_st.pval = '0;
        if (st.pval != '0 && st.wen && !st.busy)
        begin
          next_st.busy = 1'b1;
          next_st.bcy  = CW'(WR_CYCLES);
          for (int i = 0; i < PAGE; i++)
          begin
            if (st.pval[i])
              next_st.mem[{st.ptr[AW-1:PW], PW'(i)}] = st.pbuf[i];
          end
        end
      end
      else
      begin
        unique case (st.ist)
          I_IDLE:
            next_st.oe = 1'b0;
          I_DEV, I_WADDR, I_WDATA:
          begin
            if (scl_rise)
            begin
              next_st.sh   = {st.sh[6:0], st.sda_f};
              next_st.bcnt = st.bcnt + 4'h1;
            end
            else if (scl_fall && st.bcnt == `DMSEP_BYTE_BITS)
            begin
              next_st.bcnt = 4'h0;
              next_st.ist  = I_ACK;
              next_st.oe   = 1'b1;
              if (st.ist == I_DEV)
              begin
                if (st.sh[7:1] != `DMSEP_DEV_ADDR || st.busy)
                begin
                  next_st.ist = I_IDLE;
                  next_st.oe  = 1'b0;
                end
                else
                begin
                  next_st.mode   = DMSEP_BIDIR;
                  next_st.ist_nx = st.sh[0] ? I_RDATA : I_WADDR;
                end
              end
              else if (st.ist == I_WADDR)
              begin
                next_st.ptr    = st.sh[AW-1:0];
                next_st.ist_nx = I_WDATA;
              end
              else
              begin
                // Low pointer bits roll within the page, so a long
                // burst overwrites the oldest bytes first.
                next_st.pbuf[st.ptr[PW-1:0]] = st.sh;
                next_st.pval[st.ptr[PW-1:0]] = 1'b1;
                next_st.ptr[PW-1:0] = st.ptr[PW-1:0] + 1'b1;
                next_st.ist_nx = I_WDATA;
              end
            end
          end
          I_ACK:
          begin
            if (scl_fall)
            begin
              next_st.ist = st.ist_nx;
              next_st.oe  = 1'b0;
              if (st.ist_nx == I_RDATA)
              begin
                next_st.sh   = st.mem[st.ptr];
                next_st.oe   = ~st.mem[st.ptr][7];
                next_st.bcnt = 4'h1;
              end
            end
          end
          I_RDATA:
          begin
            if (scl_fall)
            begin
              if (st.bcnt == `DMSEP_BYTE_BITS)
              begin
                next_st.oe  = 1'b0;
                next_st.ist = I_RACK;
                next_st.ptr = st.ptr + 1'b1;
              end
              else
              begin
                next_st.sh   = {st.sh[6:0], 1'b0};
                next_st.oe   = ~st.sh[6];
                next_st.bcnt = st.bcnt + 4'h1;
              end
            end
          end
          I_RACK:
          begin
            if (scl_rise)
              next_st.mack = ~st.sda_f;
            else if (scl_fall)
            begin
              if (st.mack)
              begin
                next_st.ist  = I_RDATA;
                next_st.sh   = st.mem[st.ptr];
                next_st.oe   = ~st.mem[st.ptr][7];
                next_st.bcnt = 4'h1;
              end
              else
              begin
                next_st.ist = I_IDLE;
                next_st.oe  = 1'b0;
              end
            end
          end
        endcase
      end
    end
    if (srst_i)
    begin
      next_st       = '0;
      {next_st.scl_m, next_st.scl_s, next_st.scl_p, next_st.scl_f} = 4'hF;
      {next_st.sda_m, next_st.sda_s, next_st.sda_p, next_st.sda_f} = 4'hF;
      next_st.mode  = DMSEP_STREAM;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st <= next_st;
  end

  assign sda_o            = 1'b0;
  assign sda_oe_o         = st.oe;
  assign stat_o.mode      = st.mode;
  assign stat_o.busy      = st.busy;
  assign stat_o.wr_enable = st.wen;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_init_release: assert property (
    (st.mode == DMSEP_STREAM && st.init != `DMSEP_INIT_PULSES)
      |-> !st.oe)
    else $error("SDA driven during stream initialisation");
  a_stream_bit: assert property (
    (st.mode == DMSEP_STREAM && vrise && !scl_fall &&
     st.init == `DMSEP_INIT_PULSES && st.bit_idx < 4'h8)
      |=> st.oe == ~$past(exp_bit))
    else $error("Stream bit does not match memory MSB-first");
  a_stream_wrap: assert property (
    (st.mode == DMSEP_STREAM && vrise && !scl_fall &&
     st.init == `DMSEP_INIT_PULSES && st.bit_idx == 4'h8 &&
     st.saddr == AW'(DEPTH - 1))
      |=> st.saddr == '0 && st.bit_idx == 4'h0)
    else $error("Stream pointer failed to wrap to zero");
  a_enter_trans: assert property (
    (st.mode == DMSEP_STREAM && scl_fall)
      |=> st.mode == DMSEP_TRANS && !st.oe)
    else $error("SCL fall did not enter transition state");
  a_pulse_clear: assert property (
    (st.mode == DMSEP_TRANS && scl_fall) |=> st.pcnt == 8'h00)
    else $error("Pulse counter not cleared by SCL fall");
  a_revert_stream: assert property (
    (st.mode == DMSEP_TRANS && vrise && !scl_fall && st.scl_f &&
     st.pcnt == `DMSEP_REVERT_LAST)
      |=> st.mode == DMSEP_STREAM && st.saddr == '0)
    else $error("No return to streaming after 128 pulses");
  a_bidir_locked: assert property (
    st.mode == DMSEP_BIDIR |=> st.mode == DMSEP_BIDIR)
    else $error("Slave mode left without power loss");
  a_no_ack_busy: assert property (
    (st.ist == I_DEV && scl_fall && st.bcnt == 4'h8 && st.busy &&
     !start_c && !stop_c)
      |=> st.ist == I_IDLE && !st.oe)
    else $error("Address acknowledged while programming");
  a_nack_release: assert property (
    (st.ist == I_RACK && scl_fall && !st.mack && !start_c &&
     !stop_c) |=> !st.oe ##1 !st.oe)
    else $error("SDA not released after master NACK");
  a_busy_len: assert property (
    $rose(st.busy) |-> st.busy [*8])
    else $error("Write cycle ended too early");

  c_revert: cover property (
    st.mode == DMSEP_TRANS ##1 st.mode == DMSEP_STREAM);
  c_bidir: cover property (
    st.mode == DMSEP_TRANS ##1 st.mode == DMSEP_BIDIR);
  c_program: cover property ($rose(st.busy));
  c_read: cover property (st.ist == I_RDATA ##1 st.ist == I_RACK);

endmodule
